// [adc_ctl_pkg.sv]
// Shared constants and types for converter range and clock control
`default_nettype none

package adc_ctl_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] PRIMARY_OFS = 4'h0;
    localparam logic [3:0] SECONDARY_OFS = 4'h1;
    localparam logic [3:0] STATUS_OFS = 4'h2;
    localparam logic [3:0] DATA_OFS = 4'h3;

    // Primary setup register fields
    localparam int INSPAN_BIT = 0;
    localparam int REFSPAN_BIT = 1;
    localparam logic [1:0] PRIMARY_RST = 2'h0;

    // Secondary setup register fields
    localparam int EXTRANGE_BIT = 0;
    localparam int CLKSRC_BIT = 1;
    localparam int CLKDIV_BIT = 2;
    localparam int LOWSPEED_BIT = 3;
    localparam int OSR_LSB = 4;
    localparam int OSR_W = 3;
    localparam logic [6:0] SECONDARY_RST = 7'h00;

    // Status register fields
    localparam int STAT_SAT_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_SRC_BIT = 2;
    localparam int STAT_SPAN2X_BIT = 3;

    // Timing
    localparam int CLK_MHZ = 40;
    localparam int LOCKOUT_US = 150;
    localparam int LOCKOUT_CYC = LOCKOUT_US * CLK_MHZ;
    localparam int OSC_HS_DIV = 2;
    localparam int OSC_LS_MULT = 8;
    localparam int EXT_DIV = 8;
    localparam int OSR_BASE = 32;
    localparam int OSR_CNT_W = 13;

    // Output code limits
    localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
    localparam logic [23:0] CODE_MIN = 24'h800000;

    typedef enum logic {SRC_INTERNAL, SRC_EXTERNAL} clk_src_t;

endpackage : adc_ctl_pkg

`default_nettype wire

// [clock_ctl_if.sv]
// Signals between the control top and the master clock selector
`timescale 1ns/1ps
`default_nettype none

interface clock_ctl_if;
    logic src_sel;
    logic ext_div;
    logic low_speed;
    logic mclk_tick;
    logic mod_tick;
    logic active_src;
    logic src_changed;

    modport mux
    (
        input src_sel,
        input ext_div,
        input low_speed,
        output mclk_tick,
        output mod_tick,
        output active_src,
        output src_changed
    );

    modport ctl
    (
        output src_sel,
        output ext_div,
        output low_speed,
        input mclk_tick,
        input mod_tick,
        input active_src,
        input src_changed
    );
endinterface : clock_ctl_if

`default_nettype wire

// [master_clock_select.sv]
// Master clock source selection, divide and modulator clock enable
`timescale 1ns/1ps
`default_nettype none

module master_clock_select
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ext_clk_pin,
    clock_ctl_if.mux cc
);
    logic [2:0] ext_sync_r;
    logic ext_edge;
    logic [2:0] ext_div_cnt_r;
    logic ext_tick;
    logic [4:0] osc_cnt_r;
    logic [4:0] osc_limit;
    logic osc_tick;
    logic active_r;
    logic half_r;
    logic changed_r;

    // Pin synchroniser, edge taken between second and third stage
    always_ff @(posedge clk_sys)
        if (!resetn)
            ext_sync_r <= 3'h0;
        else
            ext_sync_r <= {ext_sync_r[1:0], ext_clk_pin};
    assign ext_edge = ext_sync_r[1] & ~ext_sync_r[2];

    // Optional divide by eight of the external clock
    always_ff @(posedge clk_sys)
        if (!resetn)
            ext_div_cnt_r <= 3'h0;
        else if (ext_edge)
            ext_div_cnt_r <= ext_div_cnt_r + 3'h1;
    assign ext_tick = ext_edge & (!cc.ext_div
        || ext_div_cnt_r == 3'(adc_ctl_pkg::EXT_DIV - 1)); // R11

    // Internal oscillator rate follows speed mode
    assign osc_limit = cc.low_speed
        ? 5'(adc_ctl_pkg::OSC_HS_DIV * adc_ctl_pkg::OSC_LS_MULT - 1)
        : 5'(adc_ctl_pkg::OSC_HS_DIV - 1); // R9
    always_ff @(posedge clk_sys)
        if (!resetn)
            osc_cnt_r <= 5'h00;
        else if (osc_cnt_r >= osc_limit)
            osc_cnt_r <= 5'h00;
        else
            osc_cnt_r <= osc_cnt_r + 5'h01;
    assign osc_tick = (osc_cnt_r >= osc_limit);

    // Switch only on a tick of the new source, so no tick is cut short
    always_ff @(posedge clk_sys)
        if (!resetn)
        begin
            active_r <= 1'b0; // R8
            changed_r <= 1'b0;
        end
        else
        begin
            changed_r <= 1'b0;
            if (cc.src_sel != active_r
                && (cc.src_sel ? ext_tick : osc_tick)) // R15
            begin
                active_r <= cc.src_sel;
                changed_r <= 1'b1;
            end
        end

    assign cc.mclk_tick = active_r ? ext_tick : osc_tick;
    assign cc.active_src = active_r;
    assign cc.src_changed = changed_r;

    // Modulator clock is master clock halved
    always_ff @(posedge clk_sys)
        if (!resetn)
            half_r <= 1'b0;
        else if (cc.mclk_tick)
            half_r <= ~half_r;
    assign cc.mod_tick = cc.mclk_tick & half_r; // R7

endmodule : master_clock_select

`default_nettype wire

// [code_span_scaler.sv]
// Output code scaling for standard and extended input span
`timescale 1ns/1ps
`default_nettype none

module code_span_scaler
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic load,
    input wire logic extended,
    input wire logic signed [24:0] raw,
    output logic [23:0] code_r
);
    logic signed [27:0] scaled;

    // Clip a wide value to the 24-bit code limits
    function automatic logic [23:0] clip24(input logic signed [27:0] v);
        if (v > $signed({4'h0, adc_ctl_pkg::CODE_MAX}))
            clip24 = adc_ctl_pkg::CODE_MAX;
        else if (v < $signed({4'hF, adc_ctl_pkg::CODE_MIN}))
            clip24 = adc_ctl_pkg::CODE_MIN;
        else
            clip24 = v[23:0];
    endfunction : clip24

    // Extended span places full code at 1.25 times full scale
    always_comb
        if (extended)
            scaled = 28'(($signed({{3{raw[24]}}, raw}) * 4) / 5); // R3
        else
            scaled = {{3{raw[24]}}, raw};

    always_ff @(posedge clk_sys)
        if (!resetn)
            code_r <= 24'h000000;
        else if (load)
            code_r <= clip24(scaled);

endmodule : code_span_scaler

`default_nettype wire

// [adc_range_clock_control.sv]
// Range, reference, clock and saturation control of the converter
// Functional notes
// R1: Input span bit picks plus-minus one or two times reference.
// R2: High reference span forces the single input span.
// R3: Extended mode widens span by a quarter, full codes at 1.25x.
// R4: Saturation flag latched per conversion, refreshed at next completion.
// R5: Host sets reference span to match the applied reference.
// R6: Host prefers low reference span where both ranges fit.
// R7: Modulator clock is the master clock divided by two.
// R8: After reset the internal oscillator is the clock source.
// R9: Internal oscillator rate follows speed mode automatically.
// R10: Host supplies external clock before selecting it.
// R11: Clock divide bit divides the external clock by eight.
// R12: Host keeps external clock four cycles after switching away.
// R13: Start and reset pins ignored 150 us after source change.
// R14: Slower master clock gives proportionally slower conversions.
// R15: Source switching never produces a truncated master tick.
`timescale 1ns/1ps
`default_nettype none

module adc_range_clock_control
#(
    parameter int LOCKOUT_CYCLES = adc_ctl_pkg::LOCKOUT_CYC
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ext_clk_pin,
    input wire logic start_pin,
    input wire logic reset_pin_n,
    input wire logic sat_event,
    input wire logic signed [24:0] raw_sample,
    output logic mclk_tick,
    output logic mod_tick,
    output logic conv_done,
    output logic [23:0] conv_code,
    output logic span_2x,
    output logic start_req,
    output logic reset_req,
    output logic lockout_active
);
    clock_ctl_if cc();

    logic [1:0] primary_r;
    logic [6:0] secondary_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [2:0] start_sync_r;
    logic [2:0] rst_sync_r;
    logic [15:0] lock_cnt_r;
    logic [adc_ctl_pkg::OSR_CNT_W-1:0] osr_cnt_r;
    logic [adc_ctl_pkg::OSR_CNT_W-1:0] osr_last;
    logic conv_done_r;
    logic sat_accum_r;
    logic sat_flag_r;
    logic start_rise;
    logic rst_fall;
    logic start_req_r;
    logic reset_req_r;
    logic [adc_ctl_pkg::OSR_W-1:0] osr_sel;

    // Register write decode
    always_ff @(posedge clk_sys)
        if (!resetn)
        begin
            primary_r <= adc_ctl_pkg::PRIMARY_RST;
            secondary_r <= adc_ctl_pkg::SECONDARY_RST; // R8
        end
        else if (reg_wr)
        begin
            if (reg_addr == adc_ctl_pkg::PRIMARY_OFS)
                primary_r <= reg_wdata[1:0];
            else if (reg_addr == adc_ctl_pkg::SECONDARY_OFS)
                secondary_r <= reg_wdata[6:0];
        end

    // Settings to the clock selector, and the conversion rate select
    assign cc.src_sel = secondary_r[adc_ctl_pkg::CLKSRC_BIT];
    assign cc.ext_div = secondary_r[adc_ctl_pkg::CLKDIV_BIT];
    assign cc.low_speed = secondary_r[adc_ctl_pkg::LOWSPEED_BIT];
    assign osr_sel = secondary_r[adc_ctl_pkg::OSR_LSB +: adc_ctl_pkg::OSR_W];

    master_clock_select u_clk
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ext_clk_pin(ext_clk_pin),
        .cc(cc)
    );

    // Effective span: two-times only with low reference span
    assign span_2x = primary_r[adc_ctl_pkg::INSPAN_BIT] // R1
                     & ~primary_r[adc_ctl_pkg::REFSPAN_BIT]; // R2

    // Conversion period counted in modulator ticks
    assign osr_last = adc_ctl_pkg::OSR_CNT_W'(
        (adc_ctl_pkg::OSR_BASE << osr_sel) - 1);
    always_ff @(posedge clk_sys)
        if (!resetn)
        begin
            osr_cnt_r <= '0;
            conv_done_r <= 1'b0;
        end
        else
        begin
            conv_done_r <= 1'b0;
            if (cc.mod_tick) // R14
            begin
                if (osr_cnt_r >= osr_last)
                begin
                    osr_cnt_r <= '0;
                    conv_done_r <= 1'b1;
                end
                else
                    osr_cnt_r <= osr_cnt_r + 1'b1;
            end
        end

    // Sample scaled and held at each conversion end
    code_span_scaler u_scale
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .load(conv_done_r),
        .extended(secondary_r[adc_ctl_pkg::EXTRANGE_BIT]),
        .raw(raw_sample),
        .code_r(conv_code)
    );

    // Saturation gathered over the period, published at its end
    always_ff @(posedge clk_sys)
        if (!resetn)
        begin
            sat_accum_r <= 1'b0;
            sat_flag_r <= 1'b0;
        end
        else if (conv_done_r)
        begin
            sat_flag_r <= sat_accum_r | sat_event; // R4
            sat_accum_r <= 1'b0;
        end
        else if (sat_event)
            sat_accum_r <= 1'b1; // R4

    // Control pin synchronisers
    always_ff @(posedge clk_sys)
        if (!resetn)
        begin
            start_sync_r <= 3'h0;
            rst_sync_r <= 3'h7;
        end
        else
        begin
            start_sync_r <= {start_sync_r[1:0], start_pin};
            rst_sync_r <= {rst_sync_r[1:0], reset_pin_n};
        end
    assign start_rise = start_sync_r[1] & ~start_sync_r[2];
    assign rst_fall = ~rst_sync_r[1] & rst_sync_r[2];

    // Lockout window after each completed source change
    always_ff @(posedge clk_sys)
        if (!resetn)
            lock_cnt_r <= 16'h0000;
        else if (cc.src_changed)
            lock_cnt_r <= 16'(LOCKOUT_CYCLES); // R13
        else if (lock_cnt_r != 16'h0000)
            lock_cnt_r <= lock_cnt_r - 16'h0001;
    assign lockout_active = (lock_cnt_r != 16'h0000);

    // Pin requests pass only outside the lockout
    always_ff @(posedge clk_sys)
        if (!resetn)
        begin
            start_req_r <= 1'b0;
            reset_req_r <= 1'b0;
        end
        else
        begin
            // A pin edge in the switch cycle is dropped as well
            start_req_r <= start_rise & ~lockout_active
                           & ~cc.src_changed; // R13
            reset_req_r <= rst_fall & ~lockout_active
                           & ~cc.src_changed; // R13
        end

    // Read mux, unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        unique case (reg_addr)
            adc_ctl_pkg::PRIMARY_OFS: rdata_nxt[1:0] = primary_r;
            adc_ctl_pkg::SECONDARY_OFS: rdata_nxt[6:0] = secondary_r;
            adc_ctl_pkg::STATUS_OFS:
            begin
                rdata_nxt[adc_ctl_pkg::STAT_SAT_BIT] = sat_flag_r;
                rdata_nxt[adc_ctl_pkg::STAT_LOCK_BIT] = lockout_active;
                rdata_nxt[adc_ctl_pkg::STAT_SRC_BIT] = cc.active_src;
                rdata_nxt[adc_ctl_pkg::STAT_SPAN2X_BIT] = span_2x;
            end
            adc_ctl_pkg::DATA_OFS: rdata_nxt[23:0] = conv_code;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys)
        if (!resetn)
            rdata_r <= 32'h00000000;
        else if (reg_rd)
            rdata_r <= rdata_nxt;
        else
            rdata_r <= 32'h00000000;

    assign reg_rdata = rdata_r;
    assign mclk_tick = cc.mclk_tick;
    assign mod_tick = cc.mod_tick;
    assign conv_done = conv_done_r;
    assign start_req = start_req_r;
    assign reset_req = reset_req_r;

endmodule : adc_range_clock_control

`default_nettype wire

// [ext_clock_source.sv]
// External clock source model driving the converter clock pin
`timescale 1ns/1ps
`default_nettype none

module ext_clock_source
#(
    parameter real HALF_NS = 100.0
)
(
    input wire logic run,
    output logic clk_out
);
    // Toggles only while run, stands low otherwise
    initial clk_out = 1'b0;
    always
    begin
        #(HALF_NS);
        clk_out <= run ? ~clk_out : 1'b0;
    end
endmodule : ext_clock_source

`default_nettype wire

// [adc_range_clock_control_sva.sv]
// Port checks for the converter range and clock control
`timescale 1ns/1ps
`default_nettype none

module adc_range_clock_control_sva
#(
    parameter int LOCKOUT_CYCLES = 6000
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic sat_event,
    input wire logic signed [24:0] raw_sample,
    input wire logic mclk_tick,
    input wire logic mod_tick,
    input wire logic conv_done,
    input wire logic [23:0] conv_code,
    input wire logic span_2x,
    input wire logic start_req,
    input wire logic reset_req,
    input wire logic lockout_active
);
    logic [1:0] prim_r;
    logic ext_r;
    logic seen_r;
    logic flag_r;
    int lock_cnt_r;

    // Shadow of host-written setup bits
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            prim_r <= 2'h0;
        else if (reg_wr && reg_addr == adc_ctl_pkg::PRIMARY_OFS)
            prim_r <= reg_wdata[1:0];
    end
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            ext_r <= 1'b0;
        else if (reg_wr && reg_addr == adc_ctl_pkg::SECONDARY_OFS)
            ext_r <= reg_wdata[0];
    end

    // Expected saturation flag per conversion period
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            seen_r <= 1'b0;
        else
            seen_r <= conv_done ? 1'b0 : (seen_r | sat_event);
    end
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            flag_r <= 1'b0;
        else if (conv_done)
            flag_r <= seen_r | sat_event;
    end

    // Length of the pin lockout
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !lockout_active)
            lock_cnt_r <= 0;
        else
            lock_cnt_r <= lock_cnt_r + 1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence status_rd;
        reg_rd && reg_addr == adc_ctl_pkg::STATUS_OFS;
    endsequence
    sequence std_done;
        conv_done && !ext_r && raw_sample[24] == raw_sample[23];
    endsequence

    span_select_a: assert property (
        span_2x == (prim_r[0] && !prim_r[1]))
        else $error("effective span differs from setup");
    status_span_a: assert property (
        status_rd |=> reg_rdata[3] == $past(span_2x))
        else $error("status span bit wrong");
    sat_flag_a: assert property (
        status_rd |=> reg_rdata[0] == $past(flag_r))
        else $error("saturation flag wrong");
    code_load_a: assert property (
        std_done |=> conv_code == $past(raw_sample[23:0]))
        else $error("standard code not loaded");
    mod_half_a: assert property (mod_tick |-> mclk_tick ##1 !mod_tick)
        else $error("modulator tick not halved");
    tick_whole_a: assert property (mclk_tick |=> !mclk_tick)
        else $error("runt master tick");
    lock_start_a: assert property (lockout_active |-> !start_req)
        else $error("start during lockout");
    lock_reset_a: assert property (lockout_active |-> !reset_req)
        else $error("reset during lockout");
    lock_len_a: assert property (
        $fell(lockout_active) |-> lock_cnt_r == LOCKOUT_CYCLES)
        else $error("lockout length wrong");
endmodule : adc_range_clock_control_sva

bind adc_range_clock_control adc_range_clock_control_sva
    #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) i_adc_range_clock_control_sva
(
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sat_event(sat_event), .raw_sample(raw_sample),
    .mclk_tick(mclk_tick), .mod_tick(mod_tick), .conv_done(conv_done),
    .conv_code(conv_code), .span_2x(span_2x), .start_req(start_req),
    .reset_req(reset_req), .lockout_active(lockout_active)
);

`default_nettype wire

// [tb_adc_range_clock_control.sv]
// Self-checking bench for the converter range and clock control
`timescale 1ns/1ps
`default_nettype none

module tb_adc_range_clock_control;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic start_pin = 1'b0;
    logic reset_pin_n = 1'b1;
    logic sat_event = 1'b0;
    logic signed [24:0] raw_sample = 25'h0000000;
    logic ext_run = 1'b0;
    logic ext_clk_pin, mclk_tick, mod_tick, conv_done, span_2x;
    logic start_req, reset_req, lockout_active, s;
    logic [31:0] reg_rdata, d;
    logic [23:0] conv_code;
    logic [24:0] r;
    logic [24:0] corner [4] = '{25'h07FFFFF, 25'h1800001, 25'h0FFFFFF,
        25'h1000000};
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 58;
    int mc, md;

    adc_range_clock_control #(.LOCKOUT_CYCLES(20)) i_adc_range_clock_control
    (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk_pin),
        .start_pin(start_pin), .reset_pin_n(reset_pin_n),
        .sat_event(sat_event), .raw_sample(raw_sample),
        .mclk_tick(mclk_tick), .mod_tick(mod_tick), .conv_done(conv_done),
        .conv_code(conv_code), .span_2x(span_2x), .start_req(start_req),
        .reset_req(reset_req), .lockout_active(lockout_active)
    );
    ext_clock_source i_ext_clock_source (.run(ext_run), .clk_out(ext_clk_pin));

    // 40 MHz clock and run ceiling
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            test_done();
        end
    end

    task automatic test_done();
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            bad_count = bad_count + 1;
        end
    endtask : chk

    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Count master and modulator ticks over n cycles
    task automatic ticks(input int n);
        mc = 0;
        md = 0;
        repeat (n)
        begin
            @(posedge clk_sys);
            #1 mc = mc + ((mclk_tick === 1'b1) ? 1 : 0);
            md = md + ((mod_tick === 1'b1) ? 1 : 0);
        end
    endtask : ticks

    // Pulse a control pin and look for its request
    task automatic pin_try(input logic use_start, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk_sys);
        start_pin <= use_start;
        reset_pin_n <= use_start;
        repeat (8)
        begin
            @(posedge clk_sys);
            #1 seen = seen | ((use_start ? start_req : reset_req) === 1'b1);
        end
        start_pin <= 1'b0;
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({31'h0, seen}, {31'h0, exp});
    endtask : pin_try

    task automatic wait_lock();
        #1;
        for (int i = 0; i < 60 && lockout_active !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask : wait_lock
    task automatic wait_done();
        int i;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            #1 i = i + 1;
        end
        while (conv_done !== 1'b1 && i < 300);
    endtask : wait_done

    // Expected code: clip, with 4/5 scaling in extended span
    function automatic logic [23:0] exp_code(input logic signed [24:0] x,
        input logic ext);
        int v;
        v = ext ? (int'(x) * 4) / 5 : int'(x);
        if (v > 8388607)
            v = 8388607;
        if (v < -8388608)
            v = -8388608;
        return v[23:0];
    endfunction : exp_code

    // One checked conversion with optional saturation
    task automatic convert(input logic ext);
        wait_done();
        raw_sample <= r;
        repeat (10) @(posedge clk_sys);
        sat_event <= s;
        @(posedge clk_sys);
        sat_event <= 1'b0;
        rd(adc_ctl_pkg::STATUS_OFS, d);
        // Period before had no saturation event
        chk({31'h0, d[0]}, 32'h0);
        wait_done();
        @(posedge clk_sys);
        #1 chk({8'h0, conv_code}, {8'h0, exp_code(r, ext)});
        rd(adc_ctl_pkg::STATUS_OFS, d);
        chk({31'h0, d[0]}, {31'h0, s});
        // Flag held until the next conversion ends
        repeat (20) @(posedge clk_sys);
        rd(adc_ctl_pkg::STATUS_OFS, d);
        chk({31'h0, d[0]}, {31'h0, s});
    endtask : convert

    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values and an unmapped read
        for (int a = 0; a < 5; a++)
        begin
            rd((a == 4) ? 4'h9 : 4'(a), d);
            chk(d, 32'h0);
        end
        for (int v = 0; v < 4; v++)
        begin
            wr(adc_ctl_pkg::PRIMARY_OFS, 32'(v));
            rd(adc_ctl_pkg::STATUS_OFS, d);
            chk({31'h0, d[3]}, {31'h0, v == 1});
            chk({31'h0, span_2x}, {31'h0, v == 1});
        end
        ticks(256);
        chk(32'(mc), 32'd128);
        chk(32'(md), 32'd64);
        wr(adc_ctl_pkg::SECONDARY_OFS, 32'h8);
        repeat (40) @(posedge clk_sys);
        ticks(256);
        chk(32'(mc), 32'd16);
        chk(32'(md), 32'd8);
        // Conversions, corners then random
        for (int i = 0; i < 8; i++)
        begin
            r = (i < 4) ? corner[i] : 25'($random(seed));
            s = 1'($random(seed));
            wr(adc_ctl_pkg::SECONDARY_OFS, {31'h0, i[0]});
            convert(i[0]);
        end
        // Longer conversion period from the rate select field
        wr(adc_ctl_pkg::SECONDARY_OFS, 32'h10);
        wait_done();
        md = cycles;
        wait_done();
        chk(32'(cycles - md), 32'h100);
        // External clock in and out
        ext_run <= 1'b1;
        repeat (20) @(posedge clk_sys);
        wr(adc_ctl_pkg::SECONDARY_OFS, 32'h2);
        wait_lock();
        pin_try(1'b1, 1'b0);
        repeat (30) @(posedge clk_sys);
        pin_try(1'b1, 1'b1);
        rd(adc_ctl_pkg::STATUS_OFS, d);
        chk({31'h0, d[2]}, 32'h1);
        chk({31'h0, d[1]}, 32'h0);
        ticks(400);
        chk({31'h0, mc >= 49 && mc <= 51}, 32'h1);
        wr(adc_ctl_pkg::SECONDARY_OFS, 32'h6);
        repeat (20) @(posedge clk_sys);
        ticks(640);
        chk({31'h0, mc >= 9 && mc <= 11}, 32'h1);
        wr(adc_ctl_pkg::SECONDARY_OFS, 32'h0);
        wait_lock();
        pin_try(1'b0, 1'b0);
        repeat (30) @(posedge clk_sys);
        pin_try(1'b0, 1'b1);
        ext_run <= 1'b0;
        rd(adc_ctl_pkg::STATUS_OFS, d);
        chk({31'h0, d[2]}, 32'h0);
        // Second reset in mid-run
        wr(adc_ctl_pkg::SECONDARY_OFS, 32'h9);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(adc_ctl_pkg::SECONDARY_OFS, d);
        chk(d, 32'h0);
        test_done();
    end
endmodule : tb_adc_range_clock_control

`default_nettype wire
